/* File: rtl/srp_pkg.sv */
/*
 * Package for the string repeat prefix sequencer: prefix and opcode codes,
 * per-iteration cycle costs, widths and the request and decoded-operation carriers.
 * Assumes nothing of its surroundings.
 */
package srp_pkg;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   localparam logic [7:0] PFX_REPEAT      = 8'hF3;
   localparam logic [7:0] OP_PORT_IN_B    = 8'h6C;
   localparam logic [7:0] OP_PORT_IN_W    = 8'h6D;
   localparam logic [7:0] OP_PORT_OUT_B   = 8'h6E;
   localparam logic [7:0] OP_PORT_OUT_W   = 8'h6F;
   localparam logic [7:0] OP_COPY_B       = 8'hA4;
   localparam logic [7:0] OP_COPY_W       = 8'hA5;
   localparam logic [7:0] OP_COMPARE_B    = 8'hA6;
   localparam logic [7:0] OP_COMPARE_W    = 8'hA7;
   localparam logic [7:0] OP_FILL_B       = 8'hAA;
   localparam logic [7:0] OP_FILL_W       = 8'hAB;
   localparam logic [7:0] OP_LOAD_B       = 8'hAC;
   localparam logic [7:0] OP_LOAD_W       = 8'hAD;
   localparam logic [7:0] OP_SCAN_B       = 8'hAE;
   localparam logic [7:0] OP_SCAN_W       = 8'hAF;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int          COUNT_W        = 16;
   localparam int          COST_W         = 24;
   localparam logic [15:0] COUNT_RST      = 16'h0000;
   localparam logic [23:0] COST_RST       = 24'h00_0000;

   // ----------------------------------------------------------------
   // Cycle costs: base plus per element
   // ----------------------------------------------------------------
   localparam logic [7:0]  BASE_XFER      = 8'h08;
   localparam logic [7:0]  BASE_XFER_W8   = 8'h0C;
   localparam logic [7:0]  BASE_LDFL      = 8'h06;
   localparam logic [7:0]  BASE_LDFL_W8   = 8'h0A;
   localparam logic [7:0]  BASE_CMP       = 8'h05;
   localparam logic [7:0]  BASE_CMP_W8    = 8'h09;
   localparam logic [7:0]  PER_XFER       = 8'h08;
   localparam logic [7:0]  PER_LOAD       = 8'h0B;
   localparam logic [7:0]  PER_FILL       = 8'h09;
   localparam logic [7:0]  PER_COMPARE    = 8'h16;
   localparam logic [7:0]  PER_SCAN       = 8'h0F;

   typedef enum logic [2:0] {
      SRP_KIND_PORT_IN  = 3'h0,
      SRP_KIND_LOAD     = 3'h1,
      SRP_KIND_COPY     = 3'h2,
      SRP_KIND_PORT_OUT = 3'h3,
      SRP_KIND_FILL     = 3'h4,
      SRP_KIND_COMPARE  = 3'h5,
      SRP_KIND_SCAN     = 3'h6
   } srp_kind_e;

   typedef struct packed {
      logic [7:0]         prefix;
      logic [7:0]         opcode;
      logic [COUNT_W-1:0] count;
   } srp_req_s;

   typedef struct packed {
      srp_kind_e kind;
      logic      word;
      logic      cond;
   } srp_op_s;

endpackage

/* File: rtl/srp_sequencer.sv */
/*
 * Repeat prefix sequencer: steps one string instruction per iteration,
 * services interrupts between iterations, tracks the repeat count and
 * accumulates the documented cycle cost.
 * Assumes an execution unit that runs one string step per exec_req and
 * reports the zero flag, and an interrupt unit with a request/done pair.
 */
// Notes on behaviour
// - Prefix F3 with 6C/6D repeats port input into destination string.
// - Prefix F3 with AC/AD repeats loading source elements into accumulator.
// - Prefix F3 with A4/A5 repeats copying source string to destination.
// - Prefix F3 with 6E/6F repeats output of source string to port.
// - Prefix F3 with AA/AB repeats filling destination with accumulator.
// - Prefix F3 with A6/A7/AE/AF selects repeat-while-equal behaviour.
// - Each iteration: service interrupts, execute once, then decrement count.
// - Repeat count is an unsigned 16-bit value.
// - Count reaching zero ends repetition; next instruction follows.
// - Count tested before every iteration; zero on entry runs nothing.
// - Conditional form ends when count is zero or zero flag clear.
// - Both spellings of the repeat-while-zero prefix decode identically.
// - The prefix leaves flags unchanged; only the string step changes them.
// - Input, copy, output cost 8+8n; word forms on 8-bit bus 12+8n.
// - Load 6+11n, fill 6+9n; word forms on 8-bit bus start at 10.
// - Compare 5+22n, scan 5+15n; word forms on 8-bit bus start at 9.
`timescale 1ns/1ps

module srp_sequencer
   import srp_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire logic               start,
   input  wire srp_req_s           req,
   input  wire logic               bus8,
   input  wire logic               irq_pending,
   input  wire logic               irq_done,
   input  wire logic               exec_done,
   input  wire logic               zero_flag,
   output logic                    busy,
   output logic                    reject,
   output logic                    irq_service,
   output logic                    exec_req,
   output srp_op_s                 exec_op,
   output logic [COUNT_W-1:0]      repeat_count_register,
   output logic                    done,
   output logic [COST_W-1:0]       cycle_cost
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b00_0001,
      ST_CHECK = 6'b00_0010,
      ST_IRQ   = 6'b00_0100,
      ST_EXEC  = 6'b00_1000,
      ST_TEST  = 6'b01_0000,
      ST_DONE  = 6'b10_0000
   } srp_state_e;

   srp_op_s    dec_op;
   logic       dec_ok;
   logic [7:0] dec_base;
   logic [7:0] dec_per;

   // One prefix code serves both spellings of the while-equal form
   always_comb begin
      dec_op   = '{kind: SRP_KIND_PORT_IN, word: 1'b0, cond: 1'b0};
      dec_ok   = (req.prefix == PFX_REPEAT);
      dec_op.word = req.opcode[0];
      unique case (req.opcode)
         OP_PORT_IN_B, OP_PORT_IN_W:   dec_op.kind = SRP_KIND_PORT_IN;
         OP_LOAD_B, OP_LOAD_W:         dec_op.kind = SRP_KIND_LOAD;
         OP_COPY_B, OP_COPY_W:         dec_op.kind = SRP_KIND_COPY;
         OP_PORT_OUT_B, OP_PORT_OUT_W: dec_op.kind = SRP_KIND_PORT_OUT;
         OP_FILL_B, OP_FILL_W:         dec_op.kind = SRP_KIND_FILL;
         OP_COMPARE_B, OP_COMPARE_W: begin
            dec_op.kind = SRP_KIND_COMPARE;
            dec_op.cond = 1'b1;
         end
         OP_SCAN_B, OP_SCAN_W: begin
            dec_op.kind = SRP_KIND_SCAN;
            dec_op.cond = 1'b1;
         end
         default: dec_ok = 1'b0;
      endcase
   end

   // Word forms on the 8-bit bus pay a larger base cost
   always_comb begin
      dec_base = BASE_XFER;
      dec_per  = PER_XFER;
      unique case (dec_op.kind)
         SRP_KIND_PORT_IN, SRP_KIND_COPY, SRP_KIND_PORT_OUT: begin
            dec_base = (dec_op.word && bus8) ? BASE_XFER_W8 : BASE_XFER;
            dec_per  = PER_XFER;
         end
         SRP_KIND_LOAD: begin
            dec_base = (dec_op.word && bus8) ? BASE_LDFL_W8 : BASE_LDFL;
            dec_per  = PER_LOAD;
         end
         SRP_KIND_FILL: begin
            dec_base = (dec_op.word && bus8) ? BASE_LDFL_W8 : BASE_LDFL;
            dec_per  = PER_FILL;
         end
         SRP_KIND_COMPARE: begin
            dec_base = (dec_op.word && bus8) ? BASE_CMP_W8 : BASE_CMP;
            dec_per  = PER_COMPARE;
         end
         SRP_KIND_SCAN: begin
            dec_base = (dec_op.word && bus8) ? BASE_CMP_W8 : BASE_CMP;
            dec_per  = PER_SCAN;
         end
         default: begin
            dec_base = BASE_XFER;
            dec_per  = PER_XFER;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   srp_state_e         state;
   srp_state_e         next_state;
   srp_op_s            next_exec_op;
   logic [COUNT_W-1:0] next_repeat_count_register;
   logic [COST_W-1:0]  next_cycle_cost;
   logic [7:0]         per_cost;
   logic [7:0]         next_per_cost;
   logic               next_reject;

   always_comb begin
      next_state                 = state;
      next_exec_op               = exec_op;
      next_repeat_count_register = repeat_count_register;
      next_cycle_cost            = cycle_cost;
      next_per_cost              = per_cost;
      next_reject                = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (start && dec_ok) begin
               next_exec_op               = dec_op;
               next_repeat_count_register = req.count;
               next_cycle_cost            = {16'h0000, dec_base};
               next_per_cost              = dec_per;
               next_state                 = ST_CHECK;
            end else if (start) begin
               next_reject = 1'b1;
            end
         end
         ST_CHECK: begin
            if (repeat_count_register == COUNT_RST) begin
               next_state = ST_DONE;
            end else if (irq_pending) begin
               next_state = ST_IRQ;
            end else begin
               next_state = ST_EXEC;
            end
         end
         ST_IRQ: begin
            // Count and operation stay held, so the loop resumes in place
            if (irq_done) begin
               next_state = ST_CHECK;
            end
         end
         ST_EXEC: begin
            if (exec_done) begin
               next_repeat_count_register = repeat_count_register - 16'h0001;
               next_cycle_cost = cycle_cost + {16'h0000, per_cost};
               next_state      = ST_TEST;
            end
         end
         ST_TEST: begin
            // Plain form ignores the zero flag; only the count ends it
            if (exec_op.cond && !zero_flag) begin
               next_state = ST_DONE;
            end else begin
               next_state = ST_CHECK;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state                 <= ST_IDLE;
         exec_op               <= '{kind: SRP_KIND_PORT_IN, word: 1'b0, cond: 1'b0};
         repeat_count_register <= COUNT_RST;
         cycle_cost            <= COST_RST;
         per_cost              <= 8'h00;
         reject                <= 1'b0;
      end else begin
         state                 <= next_state;
         exec_op               <= next_exec_op;
         repeat_count_register <= next_repeat_count_register;
         cycle_cost            <= next_cycle_cost;
         per_cost              <= next_per_cost;
         reject                <= next_reject;
      end
   end

   // Flags are never driven here; the execution unit alone owns them
   assign busy        = (state != ST_IDLE);
   assign irq_service = (state == ST_IRQ);
   assign exec_req    = (state == ST_EXEC);
   assign done        = (state == ST_DONE);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   AST_ZERO_ENTRY: assert property ((state == ST_CHECK) && (repeat_count_register == COUNT_RST)
      |=> done)
      else $error("zero count did not finish at once");
   AST_NO_EXEC_ZERO: assert property (exec_req |-> (repeat_count_register != COUNT_RST))
      else $error("step requested with zero count");
   AST_DECREMENT: assert property (exec_req && exec_done
      |=> repeat_count_register == $past(repeat_count_register) - 16'h0001)
      else $error("count not decremented after step");
   AST_IRQ_FIRST: assert property ((state == ST_CHECK) && (repeat_count_register != COUNT_RST)
      && irq_pending |=> irq_service && !exec_req)
      else $error("pending interrupt not serviced before step");
   AST_RESUME: assert property (irq_service && irq_done
      |=> (state == ST_CHECK) && $stable(repeat_count_register))
      else $error("sequence not resumed after interrupt");
   AST_COND_STOP: assert property ((state == ST_TEST) && exec_op.cond && !zero_flag |=> done)
      else $error("while-equal form ran on with zero flag clear");
   AST_PLAIN_GOES_ON: assert property ((state == ST_TEST) && !exec_op.cond |=> state == ST_CHECK)
      else $error("plain form stopped on the zero flag");
   AST_COUNT_LOAD: assert property (!busy && start && dec_ok
      |=> repeat_count_register == $past(req.count))
      else $error("repeat count not loaded");
   AST_COST_STEP: assert property (exec_req && exec_done
      |=> cycle_cost == $past(cycle_cost) + {16'h0000, per_cost})
      else $error("cycle cost not accumulated");
   AST_COPY_BASE: assert property (!busy && start && dec_ok && (req.opcode == OP_COPY_W) && bus8
      |=> cycle_cost == {16'h0000, BASE_XFER_W8})
      else $error("wrong base cost for word copy");
   AST_REJECT: assert property (!busy && start && (req.prefix != PFX_REPEAT) |=> reject && !busy)
      else $error("bad prefix not refused");

   COV_PLAIN_RUN: cover property ((state == ST_TEST) && !exec_op.cond ##1 (state == ST_CHECK)
      ##[1:20] done);
   COV_COND_STOP: cover property ((state == ST_TEST) && exec_op.cond && !zero_flag ##1 done);
   COV_IRQ_MID: cover property (irq_service && irq_done ##1 (state == ST_CHECK));
   COV_ZERO_ENTRY: cover property (!busy && start && dec_ok && (req.count == COUNT_RST) ##2 done);

endmodule

/* File: verif/srp_exec_model.sv */
/*
 * Behavioural execution and interrupt unit facing the repeat sequencer.
 * Assumes the bench sets slow, mism_at, irq_at and steps before each run.
 */
`timescale 1ns/1ps

module srp_exec_model (
   input  wire logic ref_clk,
   input  wire logic exec_req,
   input  wire logic irq_service,
   output logic      exec_done,
   output logic      zero_flag,
   output logic      irq_pending,
   output logic      irq_done
);
   int slow    = 0;
   int mism_at = 0;
   int irq_at  = 0;
   int steps   = 0;
   int we      = 0;
   int wi      = 0;

   // Answers after slow waiting cycles; flag drops on the step numbered mism_at
   initial begin
      exec_done   = 1'b0;
      zero_flag   = 1'b1;
      irq_pending = 1'b0;
      irq_done    = 1'b0;
      forever begin
         @(posedge ref_clk);
         #1;
         if (exec_done) begin
            steps++;
            zero_flag = (steps != mism_at);
            if (steps == irq_at) irq_pending = 1'b1;
         end
         if (irq_done) irq_pending = 1'b0;
         we = exec_req ? we + 1 : 0;
         wi = irq_service ? wi + 1 : 0;
         exec_done = exec_req && (we > slow);
         irq_done  = irq_service && (wi > slow);
      end
   end
endmodule

/* File: verif/tb_top.sv */
/*
 * Self-checking bench: runs repeat requests and compares count, cost, step
 * count, interrupt count and timing with an integer model.
 * Assumes srp_pkg and the execution model file are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
   import srp_pkg::*;
   logic                 ref_clk = 1'b0;
   logic                 reset   = 1'b1;
   logic                 start   = 1'b0;
   logic                 bus8    = 1'b0;
   srp_req_s             req     = '0;
   logic                 busy, reject, irq_service, exec_req, done;
   logic                 exec_done, zero_flag, irq_pending, irq_done;
   srp_op_s              exec_op;
   logic [COUNT_W-1:0]   repeat_count_register;
   logic [COST_W-1:0]    cycle_cost;
   int                   bad_count   = 0;
   int                   checks_done = 0;
   int                   nsteps, nirq;
   logic [7:0]           ops [14] = '{8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'hA4, 8'hA5, 8'hA6,
                                      8'hA7, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF};

   srp_sequencer u_srp_sequencer (.ref_clk(ref_clk), .reset(reset), .start(start), .req(req),
      .bus8(bus8), .irq_pending(irq_pending), .irq_done(irq_done), .exec_done(exec_done),
      .zero_flag(zero_flag), .busy(busy), .reject(reject), .irq_service(irq_service),
      .exec_req(exec_req), .exec_op(exec_op), .repeat_count_register(repeat_count_register),
      .done(done), .cycle_cost(cycle_cost));

   srp_exec_model u_exec (.ref_clk(ref_clk), .exec_req(exec_req), .irq_service(irq_service),
      .exec_done(exec_done), .zero_flag(zero_flag), .irq_pending(irq_pending), .irq_done(irq_done));

   initial forever #50 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (exec_req === 1'b1 && exec_done === 1'b1) nsteps++;
      if (irq_service === 1'b1 && irq_done === 1'b1) nirq++;
   end

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // One repeat request against the model
   // ----------------------------------------------------------------
   task automatic run(input logic [7:0] pf, input logic [7:0] op, input logic [15:0] cnt,
                      input logic b8, input int mism, input int slow, input int irq_at);
      int   k, base, per, n, t, ni, fl;
      logic ok;
      ok = (pf == PFX_REPEAT);
      k = 0; base = 0; per = 0;
      case (op)
         8'h6C, 8'h6D: begin k = 0; base = 8; per = 8; end
         8'hAC, 8'hAD: begin k = 1; base = 6; per = 11; end
         8'hA4, 8'hA5: begin k = 2; base = 8; per = 8; end
         8'h6E, 8'h6F: begin k = 3; base = 8; per = 8; end
         8'hAA, 8'hAB: begin k = 4; base = 6; per = 9; end
         8'hA6, 8'hA7: begin k = 5; base = 5; per = 22; end
         8'hAE, 8'hAF: begin k = 6; base = 5; per = 15; end
         default: ok = 1'b0;
      endcase
      if (op[0] && b8) base += 4;
      // A clear flag on a while-equal step ends the run from the test step itself
      fl = (k >= 5 && mism > 0 && mism <= cnt) ? 1 : 0;
      n = (fl == 1) ? mism : cnt;
      if (irq_at >= n) irq_at = 0;
      ni = (irq_at > 0) ? 1 : 0;
      u_exec.slow = slow; u_exec.mism_at = mism; u_exec.irq_at = irq_at; u_exec.steps = 0;
      nsteps = 0; nirq = 0;
      @(posedge ref_clk); #1;
      req = '{pf, op, cnt}; bus8 = b8; start = 1'b1;
      @(posedge ref_clk); #1;
      start = 1'b0; req = srp_req_s'($urandom); bus8 = 1'($urandom);
      if (!ok) begin
         `CHK(reject, 1'b1)
         `CHK(busy, 1'b0)
         return;
      end
      t = 0;
      while (done !== 1'b1 && t < 20000) begin @(posedge ref_clk); #1; t++; end
      `CHK(t, (3 + slow) * n + 1 - fl + ni * (2 + slow))
      `CHK(nsteps, n)
      `CHK(repeat_count_register, 16'(cnt - n))
      `CHK(cycle_cost, 24'(base + per * n))
      `CHK(exec_op, srp_op_s'({3'(k), op[0], k >= 5}))
      @(posedge ref_clk); #1;
      `CHK(busy, 1'b0)
      `CHK(nirq, ni)
   endtask

   initial begin
      int i;
      void'($urandom(18447));
      repeat (20) @(posedge ref_clk);
      #1 reset = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(cycle_cost, 24'h00_0000)
      for (i = 0; i < 2; i++) begin
         foreach (ops[j]) run(PFX_REPEAT, ops[j], 16'(3 + j % 4), 1'(i), j % 3 + 1, j % 2, 0);
      end
      run(PFX_REPEAT, 8'hA4, 16'h0000, 1'b0, 0, 0, 0);
      run(PFX_REPEAT, 8'hAE, 16'h0001, 1'b0, 0, 0, 0);
      run(PFX_REPEAT, 8'hA6, 16'h0005, 1'b1, 0, 1, 0);
      run(PFX_REPEAT, 8'hAA, 16'h0006, 1'b0, 0, 2, 3);
      run(PFX_REPEAT, 8'hA7, 16'h0008, 1'b1, 6, 0, 2);
      run(PFX_REPEAT, 8'h6E, 16'h012C, 1'b1, 0, 0, 0);
      run(8'hF2, 8'hA6, 16'h0004, 1'b0, 0, 0, 0);
      run(PFX_REPEAT, 8'h90, 16'h0004, 1'b0, 0, 0, 0);
      for (i = 0; i < 30; i++) begin
         run(PFX_REPEAT, ops[$urandom_range(13)], 16'($urandom_range(24)), 1'($urandom),
             $urandom_range(8), $urandom_range(2), $urandom_range(6));
      end
      give_verdict();
   end

   initial begin
      #10000000;
      bad_count++;
      give_verdict();
   end
endmodule
